// ---- hw/lacr_regulator.v ----
// Load adaptive motor current regulator with stall stop and standby current
// Functional notes
// - Setting 255 means full module current
// - Setting quantised to 32 levels of eight
// - Standstill past delay drops to standby current
// - Delay counts 10 ms units, default 200
// - Minimum select: 0 half, 1 quarter scale
// - Decrement once per 32/8/2/1 high readings
// - Low reading increments by 1/2/4/8
// - Upper threshold is lower plus hysteresis
// - Zero load above stop speed stops motor outside standby
// - Regulation only above enable speed
`timescale 1ns/1ps
`include "lacr_map.vh"

module lacr_regulator #(
   parameter [`LACR_TICK_CNT_W-1:0] DELAY_UNIT_CYCLES = `LACR_DELAY_UNIT_CYCLES
) (
   input wire CORE_CLK,
   input wire RESET,
   input wire [`LACR_CUR_SET_W-1:0] ABSOLUTE_MAX_CURRENT,
   input wire [`LACR_CUR_SET_W-1:0] STANDBY_CURRENT_LIMIT,
   input wire ADAPTIVE_MIN_CURRENT_SELECT,
   input wire [1:0] CURRENT_DOWN_RATE,
   input wire [1:0] CURRENT_UP_STEP,
   input wire [`LACR_LOAD_W-1:0] LOAD_LOWER_THRESHOLD,
   input wire [`LACR_LOAD_W-1:0] LOAD_HYSTERESIS_DISTANCE,
   input wire [`LACR_SPEED_W-1:0] STALL_STOP_SPEED,
   input wire [`LACR_SPEED_W-1:0] ADAPTIVE_ENABLE_SPEED,
   input wire [`LACR_DELAY_W-1:0] STANDSTILL_DELAY,
   input wire [`LACR_SPEED_W-1:0] MOTOR_SPEED,
   input wire MOTOR_STANDSTILL,
   input wire [`LACR_LOAD_W-1:0] LOAD_VALUE,
   input wire LOAD_VALID,
   input wire STALL_CLEAR,
   output reg [`LACR_CUR_LVL_W-1:0] MOTOR_CURRENT_LEVEL,
   output reg MOTOR_STOP,
   output reg STALL_EVENT,
   output reg ADAPTIVE_ACTIVE,
   output reg STANDBY_ACTIVE
);

   // One-hot operating states
   localparam [3:0] ST_FULL = 4'h1;
   localparam [3:0] ST_ADAPT = 4'h2;
   localparam [3:0] ST_STANDBY = 4'h4;
   localparam [3:0] ST_STALL = 4'h8;

   // Setting 0..255 to level 0..31; 255 lands on the top level, so it is full current
   function [`LACR_CUR_LVL_W-1:0] to_level;
      input [`LACR_CUR_SET_W-1:0] setting;
      begin
         to_level = setting[`LACR_CUR_SET_W-1:`LACR_CUR_LVL_SHIFT];
      end
   endfunction

   function [`LACR_DOWN_CNT_W-1:0] down_group;
      input [1:0] code;
      begin
         case (code)
            2'h0: down_group = `LACR_DOWN_GRP_0;
            2'h1: down_group = `LACR_DOWN_GRP_1;
            2'h2: down_group = `LACR_DOWN_GRP_2;
            default: down_group = `LACR_DOWN_GRP_3;
         endcase
      end
   endfunction

   function [`LACR_CUR_LVL_W-1:0] up_step;
      input [1:0] code;
      begin
         case (code)
            2'h0: up_step = `LACR_UP_STEP_0;
            2'h1: up_step = `LACR_UP_STEP_1;
            2'h2: up_step = `LACR_UP_STEP_2;
            default: up_step = `LACR_UP_STEP_3;
         endcase
      end
   endfunction

   // Clamp a level into [lo, hi]; with the floor above the scale, only values above hi get hi and all others get the floor
   function [`LACR_CUR_LVL_W-1:0] clamp_level;
      input [`LACR_CUR_LVL_W:0] value;
      input [`LACR_CUR_LVL_W-1:0] lo;
      input [`LACR_CUR_LVL_W-1:0] hi;
      begin
         if (value > {1'b0, hi}) begin
            clamp_level = hi;
         end else if (value < {1'b0, lo}) begin
            clamp_level = lo;
         end else begin
            clamp_level = value[`LACR_CUR_LVL_W-1:0];
         end
      end
   endfunction

   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg [`LACR_CUR_LVL_W-1:0] cur_reg;
   reg [`LACR_CUR_LVL_W-1:0] cur_next;
   reg [`LACR_DOWN_CNT_W-1:0] high_cnt_reg;
   reg [`LACR_DOWN_CNT_W-1:0] high_cnt_next;
   reg stall_hold_reg;
   reg stall_hold_next;
   reg stall_hit;
   reg [`LACR_CUR_LVL_W-1:0] level_next;

   wire [`LACR_CUR_LVL_W-1:0] scale_level;
   wire [`LACR_CUR_LVL_W-1:0] standby_level;
   wire [`LACR_CUR_LVL_W-1:0] min_level;
   wire [`LACR_LOAD_W:0] upper_threshold;
   wire load_high;
   wire load_low;
   wire adapt_speed;
   wire stall_speed;
   wire standstill_expired;

   assign scale_level = to_level(ABSOLUTE_MAX_CURRENT);
   assign standby_level = to_level(STANDBY_CURRENT_LIMIT);

   // Quarter or half of the current scale as the adaptive floor
   assign min_level = (ADAPTIVE_MIN_CURRENT_SELECT == `LACR_MIN_SEL_QUARTER) ?
                      {2'h0, scale_level[`LACR_CUR_LVL_W-1:2]} :
                      {1'h0, scale_level[`LACR_CUR_LVL_W-1:1]};

   // One bit wider so a large hysteresis cannot wrap below the lower threshold
   assign upper_threshold = {1'b0, LOAD_LOWER_THRESHOLD} + {1'b0, LOAD_HYSTERESIS_DISTANCE};
   assign load_high = {1'b0, LOAD_VALUE} > upper_threshold;
   assign load_low = LOAD_VALUE < LOAD_LOWER_THRESHOLD;

   assign adapt_speed = MOTOR_SPEED > ADAPTIVE_ENABLE_SPEED;
   assign stall_speed = MOTOR_SPEED > STALL_STOP_SPEED;

   lacr_standstill_timer #(
      .TICK_CYCLES(DELAY_UNIT_CYCLES)
   ) u_standstill_timer (
      .clk(CORE_CLK),
      .rst(RESET),
      .standstill(MOTOR_STANDSTILL),
      .delay(STANDSTILL_DELAY),
      .expired(standstill_expired)
   );

   // Stall detection relies on the driver reading hitting zero at full load
   always @* begin
      stall_hit = LOAD_VALID && stall_speed && (LOAD_VALUE == {`LACR_LOAD_W{1'b0}});
   end

   // Stall latch: a new stall in the clearing cycle keeps the motor stopped
   always @* begin
      stall_hold_next = stall_hold_reg;
      if (STALL_CLEAR) begin
         stall_hold_next = 1'b0;
      end
      if (stall_hit) begin
         stall_hold_next = 1'b1;
      end
   end

   // Operating state: stall beats standby entry, standby beats regulation; a stall seen in standby is not acted on
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_FULL: begin
            if (stall_hit) begin
               state_next = ST_STALL;
            end else if (standstill_expired) begin
               state_next = ST_STANDBY;
            end else if (adapt_speed) begin
               state_next = ST_ADAPT;
            end
         end
         ST_ADAPT: begin
            if (stall_hit) begin
               state_next = ST_STALL;
            end else if (standstill_expired) begin
               state_next = ST_STANDBY;
            end else if (!adapt_speed) begin
               state_next = ST_FULL;
            end
         end
         ST_STANDBY: begin
            if (!MOTOR_STANDSTILL) begin
               state_next = adapt_speed ? ST_ADAPT : ST_FULL;
            end
         end
         ST_STALL: begin
            if (!stall_hold_next) begin
               state_next = ST_FULL;
            end
         end
         default: begin
            state_next = ST_FULL;
         end
      endcase
   end

   // Regulated level and the run of consecutive high readings
   always @* begin
      cur_next = clamp_level({1'b0, cur_reg}, min_level, scale_level);
      high_cnt_next = high_cnt_reg;
      if (state_reg == ST_STALL) begin
         // A stall freezes the level it found; the stalling zero reading is not a low one
         cur_next = cur_reg;
         high_cnt_next = {`LACR_DOWN_CNT_W{1'b0}};
      end else if (state_reg != ST_ADAPT) begin
         // Outside regulation the level sits at the scale so that re-entry starts from full current
         cur_next = scale_level;
         high_cnt_next = {`LACR_DOWN_CNT_W{1'b0}};
      end else if (LOAD_VALID && !stall_hit) begin
         if (load_high) begin
            if (high_cnt_reg + 1'b1 >= down_group(CURRENT_DOWN_RATE)) begin
               high_cnt_next = {`LACR_DOWN_CNT_W{1'b0}};
               cur_next = clamp_level({1'b0, cur_reg} - 1'b1, min_level, scale_level);
               if (cur_reg == {`LACR_CUR_LVL_W{1'b0}}) begin
                  cur_next = min_level;
               end
            end else begin
               high_cnt_next = high_cnt_reg + 1'b1;
            end
         end else begin
            // Any reading at or below the upper threshold breaks the run
            high_cnt_next = {`LACR_DOWN_CNT_W{1'b0}};
            if (load_low) begin
               cur_next = clamp_level({1'b0, cur_reg} + {1'b0, up_step(CURRENT_UP_STEP)},
                                      min_level, scale_level);
            end
         end
      end
   end

   // Level handed to the driver
   always @* begin
      case (state_next)
         ST_STANDBY: level_next = standby_level;
         ST_ADAPT: level_next = cur_next;
         ST_STALL: level_next = cur_reg;
         default: level_next = scale_level;
      endcase
   end

   always @(posedge CORE_CLK) begin
      if (RESET) begin
         state_reg <= ST_FULL;
         cur_reg <= {`LACR_CUR_LVL_W{1'b0}};
         high_cnt_reg <= {`LACR_DOWN_CNT_W{1'b0}};
         stall_hold_reg <= 1'b0;
         MOTOR_CURRENT_LEVEL <= {`LACR_CUR_LVL_W{1'b0}};
         MOTOR_STOP <= 1'b0;
         STALL_EVENT <= 1'b0;
         ADAPTIVE_ACTIVE <= 1'b0;
         STANDBY_ACTIVE <= 1'b0;
      end else begin
         state_reg <= state_next;
         cur_reg <= cur_next;
         high_cnt_reg <= high_cnt_next;
         stall_hold_reg <= stall_hold_next;
         MOTOR_CURRENT_LEVEL <= level_next;
         MOTOR_STOP <= (state_next == ST_STALL);
         STALL_EVENT <= stall_hit;
         ADAPTIVE_ACTIVE <= (state_next == ST_ADAPT);
         STANDBY_ACTIVE <= (state_next == ST_STANDBY);
      end
   end

endmodule // lacr_regulator

// ---- hw/lacr_map.vh ----
// Constants for the load adaptive current regulator
`ifndef LACR_MAP_VH
`define LACR_MAP_VH

// Clock rate and derived timing
`define LACR_CLK_HZ 40000000
`define LACR_DELAY_UNIT_MS 10
// 400000 cycles, one 10 ms unit at 40 MHz; fits the 24-bit divider with room to spare
`define LACR_DELAY_UNIT_CYCLES 24'h06_1A80
`define LACR_TICK_CNT_W 24

// Current setting and its quantisation
`define LACR_CUR_SET_W 8
`define LACR_CUR_LVL_W 5
`define LACR_CUR_FULL_SCALE 8'hFF
`define LACR_CUR_LVL_SHIFT 3

// Minimum fraction select values
`define LACR_MIN_SEL_HALF 1'h0
`define LACR_MIN_SEL_QUARTER 1'h1

// Load reading, speed and delay widths
`define LACR_LOAD_W 10
`define LACR_SPEED_W 24
`define LACR_DELAY_W 16
`define LACR_DELAY_DEFAULT 16'h00C8

// Group sizes for the down rate codes 0..3
`define LACR_DOWN_CNT_W 6
`define LACR_DOWN_GRP_0 6'h20
`define LACR_DOWN_GRP_1 6'h08
`define LACR_DOWN_GRP_2 6'h02
`define LACR_DOWN_GRP_3 6'h01

// Step sizes for the up step codes 0..3
`define LACR_UP_STEP_0 5'h01
`define LACR_UP_STEP_1 5'h02
`define LACR_UP_STEP_2 5'h04
`define LACR_UP_STEP_3 5'h08

`endif

// ---- hw/lacr_standstill_timer.v ----
// Standstill delay timer with a 10 ms time base
`timescale 1ns/1ps
`include "lacr_map.vh"

module lacr_standstill_timer #(
   parameter [`LACR_TICK_CNT_W-1:0] TICK_CYCLES = `LACR_DELAY_UNIT_CYCLES
) (
   input wire clk,
   input wire rst,
   input wire standstill,
   input wire [`LACR_DELAY_W-1:0] delay,
   output wire expired
);

   reg [`LACR_TICK_CNT_W-1:0] div_reg;
   reg [`LACR_TICK_CNT_W-1:0] div_next;
   reg [`LACR_DELAY_W-1:0] units_reg;
   reg [`LACR_DELAY_W-1:0] units_next;
   reg tick_reg;
   reg tick_next;

   // Divider restarts with each standstill so the delay is never cut short by a stale phase
   always @* begin
      div_next = div_reg;
      tick_next = 1'b0;
      units_next = units_reg;
      if (!standstill) begin
         div_next = {`LACR_TICK_CNT_W{1'b0}};
         units_next = {`LACR_DELAY_W{1'b0}};
      end else begin
         if (div_reg >= TICK_CYCLES - 1'b1) begin
            div_next = {`LACR_TICK_CNT_W{1'b0}};
            tick_next = 1'b1;
         end else begin
            div_next = div_reg + 1'b1;
         end
         // Saturate so a very long standstill never wraps back to running current
         if (tick_reg && units_reg != {`LACR_DELAY_W{1'b1}}) begin
            units_next = units_reg + 1'b1;
         end
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         div_reg <= {`LACR_TICK_CNT_W{1'b0}};
         units_reg <= {`LACR_DELAY_W{1'b0}};
         tick_reg <= 1'b0;
      end else begin
         div_reg <= div_next;
         units_reg <= units_next;
         tick_reg <= tick_next;
      end
   end

   assign expired = standstill && (units_reg >= delay);

endmodule // lacr_standstill_timer

// ---- testbench/lacr_drv_model.sv ----
// Motor driver model that turns mechanical load into load readings
`timescale 1ns/1ps
module lacr_drv_model (
   input wire clk,
   input wire req,
   input wire [9:0] motor_load,
   output reg [9:0] load_value = 10'h3FF,
   output reg load_valid = 1'b0
);
   // Outside a reading the data is scrambled so nothing can lean on a stale value
   always @(posedge clk) begin
      load_valid <= req;
      load_value <= req ? 10'h3FF - motor_load : ~load_value;
   end
endmodule // lacr_drv_model

// ---- testbench/lacr_regulator_chk.sv ----
// Port checker for the load adaptive current regulator
`timescale 1ns/1ps
`include "lacr_map.vh"
module lacr_regulator_chk #(
   parameter [`LACR_TICK_CNT_W-1:0] DELAY_UNIT_CYCLES = `LACR_DELAY_UNIT_CYCLES
) (
   input wire CORE_CLK,
   input wire RESET,
   input wire [`LACR_CUR_SET_W-1:0] ABSOLUTE_MAX_CURRENT,
   input wire [`LACR_CUR_SET_W-1:0] STANDBY_CURRENT_LIMIT,
   input wire ADAPTIVE_MIN_CURRENT_SELECT,
   input wire [1:0] CURRENT_DOWN_RATE,
   input wire [1:0] CURRENT_UP_STEP,
   input wire [`LACR_LOAD_W-1:0] LOAD_LOWER_THRESHOLD,
   input wire [`LACR_LOAD_W-1:0] LOAD_HYSTERESIS_DISTANCE,
   input wire [`LACR_SPEED_W-1:0] STALL_STOP_SPEED,
   input wire [`LACR_SPEED_W-1:0] ADAPTIVE_ENABLE_SPEED,
   input wire [`LACR_SPEED_W-1:0] MOTOR_SPEED,
   input wire MOTOR_STANDSTILL,
   input wire [`LACR_LOAD_W-1:0] LOAD_VALUE,
   input wire LOAD_VALID,
   input wire STALL_CLEAR,
   input wire [`LACR_CUR_LVL_W-1:0] MOTOR_CURRENT_LEVEL,
   input wire MOTOR_STOP,
   input wire STALL_EVENT,
   input wire ADAPTIVE_ACTIVE,
   input wire STANDBY_ACTIVE
);
   wire [4:0] scale_lvl = ABSOLUTE_MAX_CURRENT[7:3];
   wire [4:0] stby_lvl = STANDBY_CURRENT_LIMIT[7:3];
   wire [4:0] floor_lvl = ADAPTIVE_MIN_CURRENT_SELECT ? scale_lvl >> 2 : scale_lvl >> 1;
   wire [10:0] upper = {1'b0, LOAD_LOWER_THRESHOLD} + {1'b0, LOAD_HYSTERESIS_DISTANCE};
   wire [5:0] up_sum = {1'b0, MOTOR_CURRENT_LEVEL} + (6'h01 << CURRENT_UP_STEP);
   wire [5:0] up_cap = up_sum > {1'b0, scale_lvl} ? {1'b0, scale_lvl} : up_sum;
   wire [4:0] down_cap = MOTOR_CURRENT_LEVEL > floor_lvl ? MOTOR_CURRENT_LEVEL - 5'h01 : floor_lvl;
   wire stall_hit = LOAD_VALID && LOAD_VALUE == 10'h000 && MOTOR_SPEED > STALL_STOP_SPEED;
   // A zero reading above stall speed is a stall, not a low reading
   wire regulating = ADAPTIVE_ACTIVE && LOAD_VALID && !MOTOR_STANDSTILL && !stall_hit
      && MOTOR_SPEED > ADAPTIVE_ENABLE_SPEED;
   default clocking dc @(posedge CORE_CLK);
   endclocking
   default disable iff (RESET);
   sequence high_read;
      regulating && {1'b0, LOAD_VALUE} > upper;
   endsequence
   sequence low_read;
      regulating && LOAD_VALUE < LOAD_LOWER_THRESHOLD;
   endsequence
   sequence band_read;
      regulating && {1'b0, LOAD_VALUE} <= upper && LOAD_VALUE >= LOAD_LOWER_THRESHOLD;
   endsequence
   sequence stop_held;
      MOTOR_STOP ##1 MOTOR_STOP;
   endsequence
   step_down_a: assert property (high_read ##0 CURRENT_DOWN_RATE == 2'h3
      |=> MOTOR_CURRENT_LEVEL == $past(down_cap))
      else $error("level missed a single reading decrement");
   step_up_a: assert property (low_read |=> MOTOR_CURRENT_LEVEL == $past(up_cap))
      else $error("level missed a low reading increment");
   band_hold_a: assert property (band_read |=> $stable(MOTOR_CURRENT_LEVEL))
      else $error("level moved on a reading inside the band");
   level_bounds_a: assert property (ADAPTIVE_ACTIVE |-> MOTOR_CURRENT_LEVEL >= $past(floor_lvl)
      && MOTOR_CURRENT_LEVEL <= $past(scale_lvl))
      else $error("adaptive level outside floor and scale");
   standby_level_a: assert property (STANDBY_ACTIVE |-> MOTOR_CURRENT_LEVEL == $past(stby_lvl))
      else $error("standby level differs from standby setting");
   stall_level_a: assert property (stop_held |-> $stable(MOTOR_CURRENT_LEVEL))
      else $error("level moved while stopped on stall");
   adapt_gate_a: assert property (ADAPTIVE_ACTIVE |-> $past(MOTOR_SPEED) > $past(ADAPTIVE_ENABLE_SPEED))
      else $error("regulation active at or below enable speed");
   stall_stop_a: assert property (stall_hit |=> MOTOR_STOP)
      else $error("zero reading above stall speed did not stop");
   event_cause_a: assert property (STALL_EVENT |-> $past(stall_hit))
      else $error("stall event without a stalling reading");
   stop_latch_a: assert property (MOTOR_STOP && !STALL_CLEAR |=> MOTOR_STOP)
      else $error("stop released without clear");
   full_level_a: assert property (!$past(RESET) && !ADAPTIVE_ACTIVE && !STANDBY_ACTIVE && !MOTOR_STOP
      |-> MOTOR_CURRENT_LEVEL == $past(scale_lvl))
      else $error("full current level differs from scale");
   standby_exit_a: assert property (STANDBY_ACTIVE && !MOTOR_STANDSTILL |=> !STANDBY_ACTIVE)
      else $error("standby held after motion resumed");
endmodule // lacr_regulator_chk

// ---- testbench/tb_top.sv ----
// Self-checking bench for the load adaptive current regulator
`timescale 1ns/1ps
module tb_top;
   localparam [23:0] UNIT = 24'h00_0005;
   reg clk = 1'b0, rst = 1'b1, sel = 1'b0, stand = 1'b0, sclr = 1'b0, req = 1'b0;
   reg [7:0] amax = 8'hFF, stby = 8'h40;
   reg [1:0] down = 2'h0, up = 2'h0;
   reg [23:0] spd = 24'h00_0000;
   reg [9:0] mload = 10'h000;
   wire [9:0] lval;
   wire lv, stop, sev, act, sba;
   wire [4:0] lvl;
   integer fails = 0, num_checks = 0, el = 31, sc = 31, fl = 0, cnt = 0, ad = 0, st = 0, r, d;
   lacr_drv_model drv_u (.clk(clk), .req(req), .motor_load(mload), .load_value(lval), .load_valid(lv));
   lacr_regulator #(.DELAY_UNIT_CYCLES(UNIT)) dut_u (.CORE_CLK(clk), .RESET(rst), .ABSOLUTE_MAX_CURRENT(amax),
      .STANDBY_CURRENT_LIMIT(stby), .ADAPTIVE_MIN_CURRENT_SELECT(sel), .CURRENT_DOWN_RATE(down),
      .CURRENT_UP_STEP(up), .LOAD_LOWER_THRESHOLD(10'h12C), .LOAD_HYSTERESIS_DISTANCE(10'h064),
      .STALL_STOP_SPEED(24'h00_1388), .ADAPTIVE_ENABLE_SPEED(24'h00_03E8), .STANDSTILL_DELAY(16'h0002),
      .MOTOR_SPEED(spd), .MOTOR_STANDSTILL(stand), .LOAD_VALUE(lval), .LOAD_VALID(lv), .STALL_CLEAR(sclr),
      .MOTOR_CURRENT_LEVEL(lvl), .MOTOR_STOP(stop), .STALL_EVENT(sev), .ADAPTIVE_ACTIVE(act), .STANDBY_ACTIVE(sba));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task close_out;
      begin
         $display("checks %0d fails %0d", num_checks, fails);
         if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
         end else begin
            $display("[ FAIL ]");
         end
         $finish;
      end
   endtask
   task cmp_lvl(input integer e);
      begin
         num_checks = num_checks + 1;
         if (lvl !== e[4:0]) begin
            fails = fails + 1;
            $display("wrong value level exp %0d got %0d", e, lvl);
         end
      end
   endtask
   task cmp_bit(input [55:0] nm, input e, input g);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin
            fails = fails + 1;
            $display("wrong value %0s exp %b got %b", nm, e, g);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   // One reading through the driver model, then the integer model predicts the outputs
   task rd(input [9:0] ld);
      begin
         @(posedge clk);
         req <= 1'b1;
         mload <= ld;
         @(posedge clk);
         req <= 1'b0;
         tick(1);
         r = 1023 - ld;
         if (r == 0 && spd > 5000) begin
            st = 1;
            ad = 0;
         end else if (ad && r > 400) begin
            cnt = cnt + 1;
            if (cnt == (down == 3 ? 1 : 32 >> (2 * down))) begin
               cnt = 0;
               el = el > fl ? el - 1 : fl;
            end
         end else if (ad) begin
            cnt = 0;
            if (r < 300) el = el + (1 << up) > sc ? sc : el + (1 << up);
         end
         cmp_lvl(el);
         cmp_bit("stop", st[0], stop);
         cmp_bit("event", st[0] && r == 0, sev);
      end
   endtask
   initial begin
      r = $urandom(32'h99fa_c71d);
      tick(20);
      @(posedge clk) rst <= 1'b0;
      tick(3);
      cmp_lvl(31);
      @(posedge clk);
      amax <= 8'h40 + 8'($urandom % 192);
      sel <= 1'($urandom);
      stby <= 8'($urandom);
      spd <= 24'h00_03E8;
      down <= 2'h3;
      tick(2);
      sc = amax >> 3;
      fl = sel ? sc >> 2 : sc >> 1;
      el = sc;
      cmp_lvl(sc);
      rd(10'h017);
      cmp_bit("adapt", 1'b0, act);
      $display("full current test done");
      @(posedge clk) spd <= 24'h00_07D0;
      tick(3);
      cmp_bit("adapt", 1'b1, act);
      ad = 1;
      for (d = 0; d < 4; d = d + 1) begin
         @(posedge clk) down <= d[1:0];
         rd(10'h2A1);
         repeat (d == 3 ? 1 : 32 >> (2 * d)) rd(10'h20B);
      end
      repeat (20) rd(10'h20B);
      // Flip the floor select at the bottom so both floors are seen in one run
      @(posedge clk) sel <= ~sel;
      #1 fl = sel ? sc >> 2 : sc >> 1;
      if (el < fl) el = fl;
      repeat (8) rd(10'h20B);
      $display("decrement test done");
      for (d = 0; d < 4; d = d + 1) begin
         @(posedge clk) up <= d[1:0];
         rd(10'h39B);
      end
      rd(10'h3FF);
      $display("increment test done");
      @(posedge clk) spd <= 24'h00_1388;
      rd(10'h3FF);
      @(posedge clk) spd <= 24'h00_1770;
      rd(10'h3FF);
      rd(10'h20B);
      @(posedge clk) sclr <= 1'b1;
      @(posedge clk) sclr <= 1'b0;
      #1;
      st = 0;
      cmp_bit("stop", 1'b0, stop);
      cmp_lvl(sc);
      $display("stall test done");
      @(posedge clk);
      spd <= 24'h00_0000;
      stand <= 1'b1;
      ad = 0;
      // Two units of five cycles, then one edge for the tick register and one for the state
      tick(11);
      cmp_bit("standby", 1'b0, sba);
      tick(1);
      cmp_bit("standby", 1'b1, sba);
      cmp_lvl(stby >> 3);
      @(posedge clk) stand <= 1'b0;
      tick(1);
      cmp_bit("standby", 1'b0, sba);
      cmp_lvl(sc);
      $display("standby test done");
      close_out;
   end
   // The tests need well under a thousand cycles; this margin only catches a hang
   initial begin
      #400000;
      fails = fails + 1;
      close_out;
   end
endmodule // tb_top
bind lacr_regulator lacr_regulator_chk #(.DELAY_UNIT_CYCLES(DELAY_UNIT_CYCLES)) chk_u (.CORE_CLK(CORE_CLK),
   .RESET(RESET), .ABSOLUTE_MAX_CURRENT(ABSOLUTE_MAX_CURRENT), .STANDBY_CURRENT_LIMIT(STANDBY_CURRENT_LIMIT),
   .ADAPTIVE_MIN_CURRENT_SELECT(ADAPTIVE_MIN_CURRENT_SELECT), .CURRENT_DOWN_RATE(CURRENT_DOWN_RATE),
   .CURRENT_UP_STEP(CURRENT_UP_STEP), .LOAD_LOWER_THRESHOLD(LOAD_LOWER_THRESHOLD),
   .LOAD_HYSTERESIS_DISTANCE(LOAD_HYSTERESIS_DISTANCE), .STALL_STOP_SPEED(STALL_STOP_SPEED),
   .ADAPTIVE_ENABLE_SPEED(ADAPTIVE_ENABLE_SPEED), .MOTOR_SPEED(MOTOR_SPEED), .MOTOR_STANDSTILL(MOTOR_STANDSTILL),
   .LOAD_VALUE(LOAD_VALUE), .LOAD_VALID(LOAD_VALID), .STALL_CLEAR(STALL_CLEAR),
   .MOTOR_CURRENT_LEVEL(MOTOR_CURRENT_LEVEL), .MOTOR_STOP(MOTOR_STOP), .STALL_EVENT(STALL_EVENT),
   .ADAPTIVE_ACTIVE(ADAPTIVE_ACTIVE), .STANDBY_ACTIVE(STANDBY_ACTIVE));
